// >>> rtl/iss_status.sv
// status summary: individual status flag, device and questionable status registers
`timescale 1ns/1ps

// Notes on behaviour
// - flag is OR over status byte bits ANDed with poll enable mask
// - status byte bit 6 also takes part in the flag
// - flag answered on parallel poll and on the flag query
// - controller writes the poll enable mask and reads it back
// - device bit 0 is OR of static error bits 1 to 4
// - device bit 1 set while measurement impossible error exists
// - device bit 2 set while result possibly incorrect error exists
// - device bit 3 set for warning error; indicator blinks slowly red unless a critical error is also set
// - device bit 4 set for critical error; indicator blinks fast red
// - device bit 8 is reference lock; always 1 on internal source
// - on external source bit 8 shows whether synchronisation succeeded
// - questionable bit 3 follows power sub-register summary
// - questionable bit 8 follows calibration sub-register summary
// - questionable bit 9 set when power-up self-test failed
// - summary bit set when an event bit and its enable are set
// - status byte bit 1 carries device status summary
// - event registers latch conditions until read out
module iss_status #(
  parameter int BLINK_SLOW = iss_pkg::ISS_BLINK_SLOW,
  parameter int BLINK_FAST = iss_pkg::ISS_BLINK_FAST
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] stb_in,
  input wire logic [15:0] dev_enable,
  input wire logic [15:0] ques_enable,
  input wire logic static_error_nomeas,
  input wire logic static_error_errres,
  input wire logic static_error_warn,
  input wire logic static_error_crit,
  input wire logic reference_clock_source_select,
  input wire logic ref_pll_locked,
  input wire logic ques_power_summary,
  input wire logic ques_cal_summary,
  input wire logic power_up_self_test_fail,
  input wire logic parallel_poll,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire iss_pkg::iss_sel_t cmd_sel,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic ppoll_valid,
  output logic ppoll_ist,
  output logic stb_dev_summary,
  output logic stb_ques_summary,
  output logic led_red
);
  import iss_pkg::*;

  typedef struct packed {
    logic [7:0] parallel_poll_enable_mask;
    logic [15:0] dev_cond;
    logic [15:0] dev_event;
    logic [15:0] ques_cond;
    logic [15:0] ques_event;
    logic ist;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic ppoll_valid;
    logic ppoll_ist;
    logic stb_dev;
    logic stb_ques;
    logic [25:0] blink_cnt;
    logic led;
  } iss_state_t;

  iss_state_t st_q, st_d;
  logic [8:0] raw;
  logic [8:0] syn;
  logic ext_src;
  logic [15:0] dev_now, ques_now;

  // field conditions come from the device pins, so synchronise them
  assign raw = {static_error_nomeas, static_error_errres, static_error_warn,
    static_error_crit, reference_clock_source_select, ref_pll_locked, ques_power_summary,
    ques_cal_summary, power_up_self_test_fail};

  iss_sync #(.W(9)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(raw),
    .sync_out(syn)
  );

  assign ext_src = syn[4];

  // live condition words, unused positions held at zero
  always_comb begin
    dev_now = '0;
    dev_now[ISS_DEV_NOMEAS] = syn[8];
    dev_now[ISS_DEV_ERRRES] = syn[7];
    dev_now[ISS_DEV_WARN] = syn[6];
    dev_now[ISS_DEV_CRIT] = syn[5];
    dev_now[ISS_DEV_SUM] = syn[8] | syn[7] | syn[6] | syn[5];
    dev_now[ISS_DEV_LOCK] = ext_src ? syn[3] : 1'b1;
    ques_now = '0;
    ques_now[ISS_QUES_POWER] = syn[2];
    ques_now[ISS_QUES_CAL] = syn[1];
    ques_now[ISS_QUES_SELFTEST] = syn[0];
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.dev_cond = dev_now;
    st_d.ques_cond = ques_now;
    st_d.ist = |(stb_in & st_q.parallel_poll_enable_mask);
    st_d.rsp_valid = 1'b0;
    st_d.ppoll_valid = parallel_poll;
    st_d.ppoll_ist = parallel_poll ? st_q.ist : st_q.ppoll_ist;
    // event read clears, but new conditions win over the clear
    if (cmd_valid && !cmd_write && cmd_sel == ISS_SEL_DEV_EVENT) begin
      st_d.dev_event = dev_now;
    end else begin
      st_d.dev_event = st_q.dev_event | dev_now;
    end
    if (cmd_valid && !cmd_write && cmd_sel == ISS_SEL_QUES_EVENT) begin
      st_d.ques_event = ques_now;
    end else begin
      st_d.ques_event = st_q.ques_event | ques_now;
    end
    st_d.stb_dev = |(st_q.dev_event & dev_enable);
    st_d.stb_ques = |(st_q.ques_event & ques_enable);
    if (cmd_valid && cmd_write && cmd_sel == ISS_SEL_PPE) begin
      st_d.parallel_poll_enable_mask = cmd_wdata[7:0];
    end
    if (cmd_valid && !cmd_write) begin
      st_d.rsp_valid = 1'b1;
      case (cmd_sel)
        ISS_SEL_PPE: st_d.rsp_rdata = {8'h00, st_q.parallel_poll_enable_mask};
        ISS_SEL_IST: st_d.rsp_rdata = {15'h0000, st_q.ist};
        ISS_SEL_DEV_COND: st_d.rsp_rdata = st_q.dev_cond;
        ISS_SEL_DEV_EVENT: st_d.rsp_rdata = st_q.dev_event;
        ISS_SEL_QUES_COND: st_d.rsp_rdata = st_q.ques_cond;
        ISS_SEL_QUES_EVENT: st_d.rsp_rdata = st_q.ques_event;
        default: st_d.rsp_rdata = 16'h0000;
      endcase
    end
    // red indicator: fast blink on critical, slow on warning
    if (st_q.dev_cond[ISS_DEV_CRIT] || st_q.dev_cond[ISS_DEV_WARN]) begin
      if ((st_q.dev_cond[ISS_DEV_CRIT] && st_q.blink_cnt >= 26'(BLINK_FAST - 1)) ||
          (!st_q.dev_cond[ISS_DEV_CRIT] && st_q.blink_cnt >= 26'(BLINK_SLOW - 1))) begin
        st_d.blink_cnt = '0;
        st_d.led = ~st_q.led;
      end else begin
        st_d.blink_cnt = st_q.blink_cnt + 26'd1;
      end
    end else begin
      st_d.blink_cnt = '0;
      st_d.led = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.parallel_poll_enable_mask <= ISS_PPE_RST;
      st_q.dev_event <= ISS_EVENT_RST;
      st_q.ques_event <= ISS_EVENT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp_valid = st_q.rsp_valid;
  assign rsp_rdata = st_q.rsp_rdata;
  assign ppoll_valid = st_q.ppoll_valid;
  assign ppoll_ist = st_q.ppoll_ist;
  assign stb_dev_summary = st_q.stb_dev;
  assign stb_ques_summary = st_q.stb_ques;
  assign led_red = st_q.led;

  // flag follows masked status byte one cycle later
  a_ist_masking: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 st_q.ist == |($past(stb_in) & $past(st_q.parallel_poll_enable_mask)))
    else $error("flag does not match masked status byte");
  a_bit6_counts: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stb_in[6] && st_q.parallel_poll_enable_mask[6]) |=> st_q.ist)
    else $error("bit 6 ignored by flag");
  a_ppoll_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    parallel_poll |=> ppoll_valid && ppoll_ist == $past(st_q.ist))
    else $error("parallel poll answer wrong");
  a_ppe_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_valid && cmd_write && cmd_sel == ISS_SEL_PPE) ##1
    (cmd_valid && !cmd_write && cmd_sel == ISS_SEL_PPE) |=>
    rsp_valid && rsp_rdata[7:0] == $past(cmd_wdata[7:0], 2))
    else $error("mask readback mismatch");
  a_dev_sum: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q.dev_cond[0] == |st_q.dev_cond[4:1])
    else $error("device summary bit wrong");
  a_lock_internal: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ext_src |=> st_q.dev_cond[ISS_DEV_LOCK])
    else $error("lock bit low on internal source");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q.dev_cond[15:9] == '0 && st_q.dev_cond[7:5] == '0 &&
    st_q.ques_cond[2:0] == '0 && st_q.ques_cond[7:4] == '0)
    else $error("unused bit not zero");
  a_event_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_q.dev_event[1] && !(cmd_valid && !cmd_write && cmd_sel == ISS_SEL_DEV_EVENT))
    |=> st_q.dev_event[1])
    else $error("event bit lost without readout");
  a_stb_summary: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 stb_dev_summary == |($past(st_q.dev_event) & $past(dev_enable)))
    else $error("device summary in status byte wrong");
endmodule

// >>> rtl/iss_pkg.sv
// package: register layout, bit positions and command codes of the status summary block
package iss_pkg;
  // register selector codes for the controller's command/query port
  typedef enum logic [2:0] {
    ISS_SEL_PPE,
    ISS_SEL_IST,
    ISS_SEL_DEV_COND,
    ISS_SEL_DEV_EVENT,
    ISS_SEL_QUES_COND,
    ISS_SEL_QUES_EVENT,
    ISS_SEL_NONE
  } iss_sel_t;

  localparam int ISS_STB_W = 8;
  localparam int ISS_REG_W = 16;
  localparam logic [7:0] ISS_PPE_RST = 8'h00;
  localparam logic [15:0] ISS_EVENT_RST = 16'h0000;
  // device status bit positions
  localparam int ISS_DEV_SUM = 0;
  localparam int ISS_DEV_NOMEAS = 1;
  localparam int ISS_DEV_ERRRES = 2;
  localparam int ISS_DEV_WARN = 3;
  localparam int ISS_DEV_CRIT = 4;
  localparam int ISS_DEV_LOCK = 8;
  // questionable status bit positions
  localparam int ISS_QUES_POWER = 3;
  localparam int ISS_QUES_CAL = 8;
  localparam int ISS_QUES_SELFTEST = 9;
  // status byte summary bit positions
  localparam int ISS_STB_DEV = 1;
  localparam int ISS_STB_QUES = 3;
  // indicator blink half periods in cycles
  localparam int ISS_BLINK_SLOW = 62500000;
  localparam int ISS_BLINK_FAST = 12500000;
endpackage

// >>> rtl/iss_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module iss_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> verification/iss_ctrl_model.sv
// partner model: remote controller issuing commands, queries and polls
`timescale 1ns/1ps
module iss_ctrl_model (
  input wire logic sys_clk,
  output logic parallel_poll,
  output logic cmd_valid,
  output logic cmd_write,
  output iss_pkg::iss_sel_t cmd_sel,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic ppoll_valid,
  input wire logic ppoll_ist
);
  import iss_pkg::*;
  // idle port at time zero
  initial begin
    {parallel_poll, cmd_valid, cmd_write, cmd_wdata} = '0;
    cmd_sel = ISS_SEL_NONE;
  end
  // one command; answer taken just after the taking edge, while it stands
  task automatic cmd(input logic w, input iss_sel_t s, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_wdata = wd;
    @(posedge sys_clk);
    #1;
    rd = rsp_valid ? rsp_rdata : 16'hXXXX;
    // released lines show no stale value
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_sel = iss_sel_t'(~s);
    cmd_wdata = ~wd;
  endtask
  // write followed straight on by a query of the same selector
  task automatic wr_rd(input iss_sel_t s, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_sel = s;
    cmd_wdata = wd;
    @(posedge sys_clk);
    #1;
    // valid held up, write taken, query follows
    cmd_write = 1'b0;
    @(posedge sys_clk);
    #1;
    rd = rsp_valid ? rsp_rdata : 16'hXXXX;
    cmd_valid = 1'b0;
    cmd_write = 1'b1;
    cmd_sel = iss_sel_t'(~s);
    cmd_wdata = ~wd;
  endtask
  // one parallel poll pulse
  task automatic poll(output logic ist);
    @(posedge sys_clk);
    #1;
    parallel_poll = 1'b1;
    @(posedge sys_clk);
    #1;
    ist = ppoll_valid ? ppoll_ist : 1'bX;
    parallel_poll = 1'b0;
  endtask
endmodule

// >>> verification/instrument_status_summary_tb_top.sv
// testbench: command, poll and pin scenarios for the status summary block
`timescale 1ns/1ps
module instrument_status_summary_tb_top;
  import iss_pkg::*;
  logic sys_clk, sys_rst, parallel_poll, cmd_valid, cmd_write, rsp_valid, ppoll_valid;
  logic ppoll_ist, stb_dev_summary, stb_ques_summary, led_red, led_prev, ist;
  logic src, lock, pwr, cal, power_up_self_test;
  logic [3:0] errs;
  logic [7:0] stb_in;
  logic [15:0] dev_enable, ques_enable, cmd_wdata, rsp_rdata, rd;
  iss_sel_t cmd_sel;
  int errors, num_checks, n;
  iss_status #(.BLINK_SLOW(8), .BLINK_FAST(2)) iss_status_i (.sys_clk, .sys_rst, .stb_in,
    .dev_enable, .ques_enable, .static_error_nomeas(errs[0]), .static_error_errres(errs[1]),
    .static_error_warn(errs[2]), .static_error_crit(errs[3]),
    .reference_clock_source_select(src), .ref_pll_locked(lock), .ques_power_summary(pwr),
    .ques_cal_summary(cal), .power_up_self_test_fail(power_up_self_test), .parallel_poll, .cmd_valid,
    .cmd_write, .cmd_sel, .cmd_wdata, .rsp_valid, .rsp_rdata, .ppoll_valid, .ppoll_ist,
    .stb_dev_summary, .stb_ques_summary, .led_red);
  iss_ctrl_model iss_ctrl_model_i (.sys_clk, .parallel_poll, .cmd_valid, .cmd_write,
    .cmd_sel, .cmd_wdata, .rsp_valid, .rsp_rdata, .ppoll_valid, .ppoll_ist);
  // 4 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic q(input iss_sel_t s, input logic [15:0] exp);
    iss_ctrl_model_i.cmd(1'b0, s, 16'h0000, rd);
    chk(rd, exp);
  endtask
  task automatic w8(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // count indicator toggles over 64 cycles
  task automatic blink(input logic [3:0] e, input int lo, input int hi);
    errs = e;
    w8(20);
    n = 0;
    led_prev = led_red;
    repeat (64) begin
      w8(1);
      n += int'(led_red !== led_prev);
      led_prev = led_red;
    end
    chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
  // test sequence
  initial begin
    sys_rst = 1'b1;
    {stb_in, dev_enable, ques_enable, errs, src, lock, pwr, cal, power_up_self_test} = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    q(ISS_SEL_PPE, 16'h0000);
    iss_ctrl_model_i.cmd(1'b1, ISS_SEL_PPE, 16'h12A5, rd);
    iss_ctrl_model_i.cmd(1'b1, ISS_SEL_DEV_COND, 16'h005A, rd);
    q(ISS_SEL_PPE, 16'h00A5);
    q(ISS_SEL_NONE, 16'h0000);
    iss_ctrl_model_i.wr_rd(ISS_SEL_PPE, 16'hC35A, rd);
    chk(rd, 16'h005A);
    $display("test mask done");
    for (int i = 0; i < 16; i++) begin
      iss_ctrl_model_i.cmd(1'b1, ISS_SEL_PPE, {8'h00, 8'h01 << i[3:1]}, rd);
      stb_in = i[0] ? 8'h01 << i[3:1] : ~(8'h01 << i[3:1]);
      w8(3);
      iss_ctrl_model_i.poll(ist);
      chk({15'h0000, ist}, {15'h0000, i[0]});
      q(ISS_SEL_IST, {15'h0000, i[0]});
    end
    $display("test flag done");
    for (int i = 0; i < 64; i++) begin
      {lock, src, errs} = i[5:0];
      w8(5);
      q(ISS_SEL_DEV_COND, {7'h00, ~src | lock, 3'h0, errs, |errs});
    end
    for (int i = 0; i < 8; i++) begin
      {power_up_self_test, cal, pwr} = i[2:0];
      w8(5);
      q(ISS_SEL_QUES_COND, {6'h00, power_up_self_test, cal, 4'h0, pwr, 3'h0});
    end
    $display("test conditions done");
    {errs, src, power_up_self_test, cal, pwr} = '0;
    w8(5);
    iss_ctrl_model_i.cmd(1'b0, ISS_SEL_DEV_EVENT, 16'h0000, rd);
    iss_ctrl_model_i.cmd(1'b0, ISS_SEL_QUES_EVENT, 16'h0000, rd);
    {errs[0], pwr} = 2'b11;
    w8(5);
    {errs[0], pwr} = 2'b00;
    w8(5);
    q(ISS_SEL_DEV_EVENT, 16'h0103);
    q(ISS_SEL_DEV_EVENT, 16'h0100);
    q(ISS_SEL_QUES_EVENT, 16'h0008);
    q(ISS_SEL_QUES_EVENT, 16'h0000);
    $display("test events done");
    dev_enable = 16'h0010;
    errs = 4'h1;
    pwr = 1'b1;
    w8(5);
    chk({15'h0000, stb_dev_summary}, 16'h0000);
    dev_enable = 16'h0002;
    ques_enable = 16'h0008;
    w8(3);
    chk({14'h0000, stb_ques_summary, stb_dev_summary}, 16'h0003);
    $display("test summaries done");
    blink(4'h0, 0, 0);
    blink(4'h4, 7, 9);
    blink(4'hC, 26, 33);
    $display("test indicator done");
    tally_and_finish();
  end
endmodule
